// ---- core/ppf_pkg.sv ----
// Behaviour
// - Direction bit 1 selects input, 0 selects output driving the latch value.
// - With read-source bit 1, port reads return actual pin levels.
// - Read-source 1, input pin: read-modify-write stores sampled pin level.
// - Open-drain bit 1 makes the pin only pull low.
// - Clearing a peripheral clock enable stops that peripheral's clock.
// - A pin with no running peripheral stays usable for other functions.
// - Only one function is active on any pin at a time.
`default_nettype none
package ppf_pkg;
    typedef logic [31:0] ppf_word_t;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DIR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ODSEL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RDSRC = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CLKEN = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_REDIR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PINLVL = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_SET = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_CLR = 8'h20;
    localparam int RDSRC_POS = 0;
    localparam logic RST_DIR = 1'b1;
    localparam logic RST_LATCH = 1'b0;
    localparam logic RST_OD = 1'b0;
    localparam logic RST_RDSRC = 1'b0;
    localparam logic RST_CLKEN = 1'b0;
    localparam logic RST_REDIR = 1'b0;
    typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD} ppf_bus_st_t;
endpackage : ppf_pkg
`default_nettype wire

// ---- core/ppf_mux_if.sv ----
`default_nettype none
interface ppf_mux_if #(parameter int N_PINS = 8, parameter int N_PERIPH = 4);
    logic [N_PINS-1:0] latch;
    logic [N_PINS-1:0] dir;
    logic [N_PINS-1:0] od;
    logic [N_PINS-1:0] pin_lvl;
    logic [N_PERIPH-1:0] clk_en;
    logic [N_PERIPH-1:0] redir;
    logic [N_PERIPH-1:0] periph_out;
    logic [N_PERIPH-1:0] periph_oe;
    logic [N_PINS-1:0] pin_out;
    logic [N_PINS-1:0] pin_drive;
    logic [N_PINS-1:0] owned;
    logic [N_PERIPH-1:0] periph_in;
    modport mux_side (
        input latch, dir, od, pin_lvl, clk_en, redir, periph_out, periph_oe,
        output pin_out, pin_drive, owned, periph_in
    );
    modport core_side (
        output latch, dir, od, pin_lvl, clk_en, redir, periph_out, periph_oe,
        input pin_out, pin_drive, owned, periph_in
    );
endinterface : ppf_mux_if
`default_nettype wire

// ---- core/ppf_pin_mux.sv ----
`default_nettype none
module ppf_pin_mux #(
    parameter int N_PINS = 8,
    parameter int N_PERIPH = 4
) (
    ppf_mux_if.mux_side mx
);
    import ppf_pkg::*;

    // Peripheral k may sit on pin k or, when redirected, on pin k+N_PERIPH.
    for (genvar p = 0; p < N_PINS; p++) begin : g_pin
        localparam int K = p % N_PERIPH;
        localparam logic HI = (p >= N_PERIPH);
        logic val;
        logic want;
        assign mx.owned[p] = mx.clk_en[K] & (mx.redir[K] == HI);
        assign val = mx.owned[p] ? mx.periph_out[K] : mx.latch[p];
        assign want = mx.owned[p] ? mx.periph_oe[K] : ~mx.dir[p];
        assign mx.pin_out[p] = mx.od[p] ? 1'b0 : val;
        assign mx.pin_drive[p] = want & ~(mx.od[p] & val);
    end

    for (genvar k = 0; k < N_PERIPH; k++) begin : g_periph
        assign mx.periph_in[k] = mx.clk_en[k] &
            (mx.redir[k] ? mx.pin_lvl[k + N_PERIPH] : mx.pin_lvl[k]);
    end
endmodule : ppf_pin_mux
`default_nettype wire

// ---- core/ppf_port_ctl.sv ----
`default_nettype none
module ppf_port_ctl #(
    parameter int N_PINS = 8,
    parameter int N_PERIPH = 4
) (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire ppf_pkg::ppf_word_t HWDATA_I,
    input wire logic HREADY_I,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output ppf_pkg::ppf_word_t HRDATA_O,
    input wire logic [N_PINS-1:0] PIN_I,
    output logic [N_PINS-1:0] PIN_O,
    output logic [N_PINS-1:0] PIN_OE_N_O,
    input wire logic [N_PERIPH-1:0] PERIPH_OUT_I,
    input wire logic [N_PERIPH-1:0] PERIPH_OE_I,
    output logic [N_PERIPH-1:0] PERIPH_IN_O,
    output logic [N_PERIPH-1:0] PERIPH_CLK_EN_O
);
    import ppf_pkg::*;

    logic [N_PINS-1:0] latch;
    logic [N_PINS-1:0] dir;
    logic [N_PINS-1:0] od;
    logic [N_PINS-1:0] sync1;
    logic [N_PINS-1:0] pin_lvl;
    logic rd_src;
    logic [N_PERIPH-1:0] clk_en;
    logic [N_PERIPH-1:0] redir;
    ppf_bus_st_t bus_st;
    logic [ADDR_W-1:0] addr_q;
    logic acc;
    logic wr_en;
    logic [N_PINS-1:0] wmask;
    logic [N_PINS-1:0] rd_view;
    logic [N_PINS-1:0] rmw_base;
    ppf_word_t rd_word;

    ppf_mux_if #(.N_PINS(N_PINS), .N_PERIPH(N_PERIPH)) mx ();

    assign mx.latch = latch;
    assign mx.dir = dir;
    assign mx.od = od;
    assign mx.pin_lvl = pin_lvl;
    assign mx.clk_en = clk_en;
    assign mx.redir = redir;
    assign mx.periph_out = PERIPH_OUT_I;
    assign mx.periph_oe = PERIPH_OE_I;

    ppf_pin_mux #(.N_PINS(N_PINS), .N_PERIPH(N_PERIPH)) u_mux (
        .mx(mx.mux_side)
    );

    assign acc = HSEL_I & HREADY_I & HTRANS_I[1];
    assign wr_en = (bus_st == BUS_WR);
    assign wmask = HWDATA_I[N_PINS-1:0];

    assign rd_view = rd_src ? pin_lvl : latch;
    // input pins copy
    // Output pins keep their latch so a bit operation never rewrites an open-drain pin
    // that an external device holds low.
    assign rmw_base = (rd_src ? (dir & pin_lvl) | (~dir & latch) : latch);

    always_comb begin
        rd_word = '0;
        unique case (addr_q)
            OFS_DATA: rd_word[N_PINS-1:0] = rd_view;
            OFS_DIR: rd_word[N_PINS-1:0] = dir;
            OFS_ODSEL: rd_word[N_PINS-1:0] = od;
            OFS_RDSRC: rd_word[RDSRC_POS] = rd_src;
            OFS_CLKEN: rd_word[N_PERIPH-1:0] = clk_en;
            OFS_REDIR: rd_word[N_PERIPH-1:0] = redir;
            OFS_PINLVL: rd_word[N_PINS-1:0] = pin_lvl;
            default: rd_word = '0;
        endcase
    end

    // Reads take one wait state so a write just before is always seen.
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            bus_st <= BUS_IDLE;
            addr_q <= '0;
            HREADYOUT_O <= 1'b1;
            HRDATA_O <= '0;
        end else if (bus_st == BUS_RD) begin
            HRDATA_O <= rd_word;
            HREADYOUT_O <= 1'b1;
            bus_st <= BUS_IDLE;
        end else if (acc) begin
            addr_q <= HADDR_I[ADDR_W-1:0];
            bus_st <= HWRITE_I ? BUS_WR : BUS_RD;
            HREADYOUT_O <= HWRITE_I;
        end else begin
            bus_st <= BUS_IDLE;
        end
    end

    assign HRESP_O = 1'b0;

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            latch <= {N_PINS{RST_LATCH}};
        end else if (wr_en) begin
            if (addr_q == OFS_DATA) begin
                latch <= wmask;
            end else if (addr_q == OFS_SET) begin
                latch <= rmw_base | wmask;
            end else if (addr_q == OFS_CLR) begin
                latch <= rmw_base & ~wmask;
            end
        end
    end

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            dir <= {N_PINS{RST_DIR}};
            od <= {N_PINS{RST_OD}};
            rd_src <= RST_RDSRC;
        end else if (wr_en) begin
            if (addr_q == OFS_DIR) begin
                dir <= wmask;
            end
            if (addr_q == OFS_ODSEL) begin
                od <= wmask;
            end
            if (addr_q == OFS_RDSRC) begin
                rd_src <= HWDATA_I[RDSRC_POS];
            end
        end
    end

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            clk_en <= {N_PERIPH{RST_CLKEN}};
            redir <= {N_PERIPH{RST_REDIR}};
        end else if (wr_en) begin
            if (addr_q == OFS_CLKEN) begin
                clk_en <= HWDATA_I[N_PERIPH-1:0];
            end
            // locked while running
            // A running peripheral would glitch onto a new pin, so its route is held.
            if (addr_q == OFS_REDIR) begin
                redir <= (redir & clk_en) | (HWDATA_I[N_PERIPH-1:0] & ~clk_en);
            end
        end
    end

    assign PERIPH_CLK_EN_O = clk_en;

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sync1 <= '0;
            pin_lvl <= '0;
        end else begin
            sync1 <= PIN_I;
            pin_lvl <= sync1;
        end
    end

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PIN_O <= '0;
            PIN_OE_N_O <= '1;
            PERIPH_IN_O <= '0;
        end else begin
            PIN_O <= mx.pin_out;
            PIN_OE_N_O <= ~mx.pin_drive;
            PERIPH_IN_O <= mx.periph_in;
        end
    end

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (SYS_RST_I);

    a_input_no_drive: assert property (
        ##1 ((~PIN_OE_N_O) & $past(dir & ~mx.owned)) == '0)
        else $error("Input-mode pin is driven.");

    a_output_latch_val: assert property (
        ##1 ((PIN_O ^ $past(latch)) & $past(~dir & ~mx.owned & ~od)) == '0
            && ((PIN_OE_N_O) & $past(~dir & ~mx.owned & ~od)) == '0)
        else $error("Output-mode pin does not show its latch.");

    a_read_pin_level: assert property (
        (bus_st == BUS_RD && addr_q == OFS_DATA && rd_src)
        |=> HRDATA_O[N_PINS-1:0] == $past(pin_lvl) && HREADYOUT_O)
        else $error("Port read did not return pin level.");

    a_rmw_pin_copy: assert property (
        (wr_en && addr_q == OFS_SET && rd_src)
        |=> ((latch ^ $past(pin_lvl)) & $past(dir & ~wmask)) == '0)
        else $error("Bit set did not copy input pin level.");

    a_od_never_high: assert property (
        ##1 ((~PIN_OE_N_O) & PIN_O & $past(od)) == '0)
        else $error("Open-drain pin drove high.");

    a_redir_locked: assert property (
        ##1 ((redir ^ $past(redir)) & $past(clk_en)) == '0)
        else $error("Route changed while peripheral clock ran.");

    a_clk_gate_write: assert property (
        (wr_en && addr_q == OFS_CLKEN)
        |=> PERIPH_CLK_EN_O == $past(HWDATA_I[N_PERIPH-1:0]) ##1 PERIPH_IN_O == '0
            || $past(PERIPH_CLK_EN_O) != '0)
        else $error("Clock enable write not applied.");

    a_free_pin_gpio: assert property (
        (mx.owned & ~{clk_en, clk_en}) == '0)
        else $error("Pin claimed by a stopped peripheral.");

    a_one_owner: assert property (
        ##1 ((~PIN_OE_N_O) & $past(mx.owned & ~{PERIPH_OE_I, PERIPH_OE_I})) == '0)
        else $error("Port logic drove a pin owned by a peripheral.");

    a_rmw_keep_bits: assert property (
        (wr_en && addr_q == OFS_CLR && !rd_src)
        |=> ((latch ^ $past(latch)) & $past(~wmask)) == '0)
        else $error("Bit clear disturbed untouched latches.");

    a_read_one_wait: assert property (
        (acc && !HWRITE_I && bus_st != BUS_RD) |=> !HREADYOUT_O ##1 HREADYOUT_O)
        else $error("Read wait state is not exactly one cycle.");

    a_latch_write: assert property (
        (wr_en && addr_q == OFS_DATA) |=> latch == $past(wmask))
        else $error("Latch write not stored.");

    a_dir_write: assert property (
        (wr_en && addr_q == OFS_DIR) |=> dir == $past(wmask))
        else $error("Direction write not stored.");

    a_od_write: assert property (
        (wr_en && addr_q == OFS_ODSEL) |=> od == $past(wmask))
        else $error("Open-drain select write not stored.");

    a_rdsrc_write: assert property (
        (wr_en && addr_q == OFS_RDSRC) |=> rd_src == $past(HWDATA_I[RDSRC_POS]))
        else $error("Read-source write not stored.");

    a_read_latch_val: assert property (
        (bus_st == BUS_RD && addr_q == OFS_DATA && !rd_src)
        |=> HRDATA_O[N_PINS-1:0] == $past(latch))
        else $error("Port read did not return latch.");

    a_rmw_out_keep: assert property (
        (wr_en && addr_q == OFS_SET && rd_src)
        |=> ((latch ^ $past(latch | wmask)) & $past(~dir)) == '0)
        else $error("Bit set rewrote an output pin latch.");

    a_clr_pin_copy: assert property (
        (wr_en && addr_q == OFS_CLR && rd_src)
        |=> ((latch ^ $past(pin_lvl)) & $past(dir & ~wmask)) == '0)
        else $error("Bit clear did not copy input pin level.");

    a_set_keep_bits: assert property (
        (wr_en && addr_q == OFS_SET && !rd_src)
        |=> ((latch ^ $past(latch)) & $past(~wmask)) == '0)
        else $error("Bit set disturbed untouched latches.");

    a_od_drive_low: assert property (
        ##1 (PIN_OE_N_O & $past(od & ~dir & ~mx.owned & ~latch)) == '0)
        else $error("Open-drain pin with latch low is not driven.");

    a_stopped_no_input: assert property (
        ##1 (PERIPH_IN_O & ~$past(clk_en)) == '0)
        else $error("Stopped peripheral still sees a pin.");

    a_periph_value: assert property (
        ##1 ((PIN_O ^ $past({PERIPH_OUT_I, PERIPH_OUT_I})) & $past(mx.owned & ~od)) == '0)
        else $error("Owned pin does not show its peripheral value.");

    a_owner_exclusive: assert property (
        (mx.owned[N_PERIPH-1:0] & mx.owned[N_PINS-1:N_PERIPH]) == '0)
        else $error("Peripheral owns two pins at once.");

    a_redir_accept: assert property (
        (wr_en && addr_q == OFS_REDIR)
        |=> ((redir ^ $past(HWDATA_I[N_PERIPH-1:0])) & $past(~clk_en)) == '0)
        else $error("Route write to stopped peripheral not stored.");

    // The two-stage synchroniser costs two edges of latency on every pin readback,
    // which software polling a pin must allow for.
    a_pin_sync: assert property (
        ##2 pin_lvl == $past(PIN_I, 2))
        else $error("Pin level not seen two edges later.");
endmodule : ppf_port_ctl
`default_nettype wire

// ---- dv/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ppf_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic hreadyout;
    logic hresp;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    ppf_word_t hwdata = 32'h0;
    ppf_word_t hrdata;
    ppf_word_t rd;
    logic [7:0] pin_in = 8'h00;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic [3:0] p_out = 4'h0;
    logic [3:0] p_oe = 4'h0;
    logic [3:0] p_in;
    logic [3:0] p_clk;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;

    ppf_port_ctl #(.N_PINS(8), .N_PERIPH(4)) dut (
        .CLOCK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hreadyout), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
        .HRDATA_O(hrdata), .PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_N_O(pin_oe_n),
        .PERIPH_OUT_I(p_out), .PERIPH_OE_I(p_oe), .PERIPH_IN_O(p_in),
        .PERIPH_CLK_EN_O(p_clk)
    );

    always #2.5 clk = ~clk;

    task test_done;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            test_done();
        end
    end

    task check(input ppf_word_t seen, input ppf_word_t exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Entered right after a rising edge; read data is taken at the closing edge.
    task bus(input logic wr_en, input logic [7:0] a, input ppf_word_t wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr_en;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task wr(input logic [7:0] a, input ppf_word_t d);
        bus(1'b1, a, d);
    endtask : wr

    task rd_chk(input logic [7:0] a, input ppf_word_t e);
        bus(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rd_chk

    task wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(OFS_DIR, 32'hff); // all pins start as inputs
        rd_chk(OFS_DATA, 32'h0); // latch reset
        rd_chk(OFS_ODSEL, 32'h0); // push-pull at reset
        rd_chk(OFS_CLKEN, 32'h0); // clocks off at reset
        rd_chk(8'h40, 32'h0); // unmapped place reads zero
        check(32'(hresp), 32'h0); // response always okay
        $display("test reset done");
        wr(OFS_DATA, 32'ha5);
        wait_cyc(2);
        check(32'(pin_oe_n), 32'hff); // input pins stay undriven
        rd_chk(OFS_DATA, 32'ha5); // latch read back
        wr(OFS_DIR, 32'hf0);
        wait_cyc(2);
        check(32'(pin_oe_n), 32'hf0); // low nibble now output
        check(32'(pin_out & ~pin_oe_n), 32'h05); // stored value appears
        $display("test direction done");
        wr(OFS_ODSEL, 32'h03);
        wait_cyc(2);
        check(32'(pin_oe_n), 32'hf1); // open drain high releases pin
        check(32'(pin_out & 8'h02), 32'h0); // open drain low pulls down
        wr(OFS_ODSEL, 32'h0);
        $display("test open drain done");
        pin_in <= 8'h2d;
        wr(OFS_RDSRC, 32'h1);
        rd_chk(OFS_DATA, 32'h2d); // pin level returned
        rd_chk(OFS_PINLVL, 32'h2d); // level register
        wr(OFS_RDSRC, 32'h0);
        rd_chk(OFS_DATA, 32'ha5); // latch returned again
        $display("test read source done");
        // Input pins copy their level, output pins keep the latch.
        wr(OFS_RDSRC, 32'h1);
        wr(OFS_SET, 32'h01);
        wr(OFS_RDSRC, 32'h0);
        rd_chk(OFS_DATA, 32'h25); // sampled level stored
        wr(OFS_CLR, 32'h04);
        rd_chk(OFS_DATA, 32'h21); // untouched bits kept
        wr(OFS_SET, 32'h02);
        rd_chk(OFS_DATA, 32'h23); // set keeps other bits
        pin_in <= 8'h6d;
        wr(OFS_RDSRC, 32'h1);
        wr(OFS_CLR, 32'h02);
        wr(OFS_RDSRC, 32'h0);
        rd_chk(OFS_DATA, 32'h61); // clear copies input pin levels
        rd_chk(OFS_SET, 32'h0); // set register reads zero
        $display("test read modify write done");
        p_oe <= 4'h1;
        wr(OFS_CLKEN, 32'h1);
        wr(OFS_REDIR, 32'h1);
        rd_chk(OFS_REDIR, 32'h0); // redirect blocked while running
        check(32'(p_clk), 32'h1); // clock enable follows register
        wait_cyc(3);
        check(32'(pin_out & 8'h0f), 32'h00); // peripheral overrides latch
        check(32'(p_in), 32'h1); // pin level routed to peripheral
        wr(OFS_CLKEN, 32'h0);
        wait_cyc(2);
        check(32'(p_clk), 32'h0); // clock stopped
        check(32'(p_in), 32'h0); // stopped peripheral sees no input
        wr(OFS_REDIR, 32'h1);
        wr(OFS_CLKEN, 32'h1);
        rd_chk(OFS_REDIR, 32'h1); // redirect accepted while stopped
        wait_cyc(3);
        check(32'(pin_oe_n), 32'he0); // peripheral moved to upper pin
        check(32'(pin_out & 8'h1f), 32'h01); // freed pin back to latch
        check(32'(p_in), 32'h0); // input taken from new pin
        $display("test redirection done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
